// ### core/gpp_defines.svh
// gpp_defines.svh: address map, bit layout, reset values and masks of the gpio port
// assumes: included by the package and the port modules, byte addresses on a 12-bit apb bus
`ifndef GPP_DEFINES_SVH
`define GPP_DEFINES_SVH

// register byte addresses
`define GPP_ADDR_LATCH   12'h000
`define GPP_ADDR_DIR     12'h004
`define GPP_ADDR_PULL    12'h008
`define GPP_ADDR_STBY    12'h00c

// pins 5, 4, 3 and 0 exist
`define GPP_IMPL_MASK    8'h39
// pin 0 has no pull-up resistor
`define GPP_NOPULL_MASK  8'h01
// n-channel open-drain pins
`define GPP_OD_MASK      8'h01
// pins wired to the external interrupt lines
`define GPP_IRQ_MASK     8'h38
// pin reached through the interrupt pin routing
`define GPP_ROUTE_MASK   8'h01
// float-select bit in the standby control register
`define GPP_FLOAT_BIT    0

// reset values
`define GPP_LATCH_RST    8'h00
`define GPP_DIR_RST      8'h00
`define GPP_PULL_RST     8'h00
`define GPP_FLOAT_RST    1'b0

`endif

// ### core/gpp_pkg.sv
// gpp_pkg.sv: types of the gpio port
// assumes: gpp_defines.svh sits next to it
package gpp_pkg;
  `include "gpp_defines.svh"

  typedef logic [7:0]  gpp_byte_t;
  typedef logic [11:0] gpp_addr_t;
  typedef logic [31:0] gpp_word_t;

  typedef struct packed {
    gpp_byte_t stage1;
    gpp_byte_t stage2;
  } gpp_sync_t;

  typedef struct packed {
    gpp_byte_t latch;
    gpp_byte_t dir;
    gpp_byte_t pull;
    logic      flt_sel;
    gpp_word_t rdata;
    gpp_byte_t pin_out;
    gpp_byte_t pin_oe;
    gpp_byte_t pull_on;
    gpp_byte_t irq_lvl;
    gpp_byte_t per_in;
  } gpp_state_t;
endpackage

// ### core/gpp_sync.sv
// gpp_sync.sv: two-stage synchroniser for the eight pin levels
// assumes: pins are asynchronous to ref_clk; only the second stage is read outside
module gpp_sync (
  // clock and control
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              en,
  // data
  input  wire gpp_pkg::gpp_byte_t d,
  output      gpp_pkg::gpp_byte_t q
);
  import gpp_pkg::*;

  gpp_sync_t s_r;
  gpp_sync_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (en) begin
      s_nxt.stage1 = d;
      s_nxt.stage2 = s_r.stage1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.stage2;
endmodule // gpp_sync

// ### core/gpp_port.sv
// gpp_port.sv: eight-bit gpio port with four pins, apb register slave
// assumes: apb master on ref_clk, pins and pad logic outside, pads resolve oe/out
//
// Summary of operation
// - direction bit 1 makes the pin an output driven from the latch.
// - latch write reaches an output pin at once.
// - latch write on an input pin is stored but not driven.
// - data read of an output-mode pin returns the latch.
// - direction bit 0 makes an input; normal read returns pin level.
// - read-modify-write read returns the latch in every mode.
// - peripheral output enable drives the pin; normal read returns pin level.
// - normal read returns pin level even when a peripheral takes it as input.
// - reset clears every direction bit, all pins inputs.
// - float select and stop/watch: pins high-z, inputs forced low.
// - pins with enabled external interrupt keep their input during float.
// - float select 0 keeps pin state unchanged in stop/watch.
// - interrupt-capable pin levels go to the interrupt circuit at all times except in float, where pins without an enabled interrupt go low.
// - pull-up bit 1 connects the pull-up, 0 disconnects it.
// - a pin driving low always has its pull-up disconnected.
// - pull-up bit 0 is read/write but pin 0 has no pull-up.
// - open-drain output pin releases to high-z on data 1.
// - bits 5, 4, 3 and 0 are the four pins, others unimplemented.
`include "gpp_defines.svh"
module gpp_port (
  // clock, reset, enable
  input  wire logic               REF_CLK,
  input  wire logic               RESET,
  input  wire logic               CLK_EN,
  // apb slave
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire gpp_pkg::gpp_addr_t PADDR,
  input  wire gpp_pkg::gpp_word_t PWDATA,
  output      gpp_pkg::gpp_word_t PRDATA,
  output      logic               PREADY,
  output      logic               PSLVERR,
  // cpu read qualifier
  input  wire logic               RMW_READ,
  // pads
  input  wire gpp_pkg::gpp_byte_t PIN_IN,
  output      gpp_pkg::gpp_byte_t PIN_OUT,
  output      gpp_pkg::gpp_byte_t PIN_OE,
  output      gpp_pkg::gpp_byte_t PULLUP_ON,
  // shared peripherals
  input  wire gpp_pkg::gpp_byte_t PERIPH_OE,
  input  wire gpp_pkg::gpp_byte_t PERIPH_OUT,
  output      gpp_pkg::gpp_byte_t PERIPH_IN,
  // standby and external interrupt circuit
  input  wire logic               STOP_WATCH_MODE,
  input  wire gpp_pkg::gpp_byte_t EXT_IRQ_EN,
  input  wire logic               IRQ_ROUTE_EN,
  output      gpp_pkg::gpp_byte_t IRQ_LEVEL
);
  import gpp_pkg::*;

  // masks as typed constants so that single bits can be selected in the pin loop
  localparam gpp_byte_t impl_m   = `GPP_IMPL_MASK;
  localparam gpp_byte_t nopull_m = `GPP_NOPULL_MASK;
  localparam gpp_byte_t od_m     = `GPP_OD_MASK;

  gpp_state_t q;
  gpp_state_t d;
  gpp_byte_t  pin_sync;
  gpp_byte_t  irq_keep;
  gpp_byte_t  pin_level;
  gpp_byte_t  drv_val;
  gpp_byte_t  drv_en;
  gpp_byte_t  pad_out;
  gpp_byte_t  pad_oe;
  gpp_byte_t  pull_on;
  gpp_byte_t  data_rd;
  gpp_word_t  rd_mux;
  logic       addr_hit;
  logic       setup_rd;
  logic       access_wr;
  logic       float_now;
  logic       float_nxt;

  gpp_sync u_sync (
    .clk (REF_CLK),
    .rst (RESET),
    .en  (CLK_EN),
    .d   (PIN_IN),
    .q   (pin_sync)
  );

  assign addr_hit  = (PADDR == `GPP_ADDR_LATCH) || (PADDR == `GPP_ADDR_DIR) ||
                     (PADDR == `GPP_ADDR_PULL)  || (PADDR == `GPP_ADDR_STBY);
  assign setup_rd  = PSEL && !PENABLE && !PWRITE;
  assign access_wr = PSEL && PENABLE && PWRITE;
  assign float_now = q.flt_sel && STOP_WATCH_MODE;
  assign float_nxt = d.flt_sel && STOP_WATCH_MODE;

  // the routed debug/counter-clock pin counts as interrupt-enabled
  assign irq_keep = (EXT_IRQ_EN & `GPP_IRQ_MASK) |
                    ({8{IRQ_ROUTE_EN}} & `GPP_ROUTE_MASK);

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      // peripheral output wins over the port latch
      assign drv_val[i] = PERIPH_OE[i] ? PERIPH_OUT[i] : d.latch[i];
      // standby float overrides direction; with float off nothing changes
      assign drv_en[i]  = (PERIPH_OE[i] | d.dir[i]) & impl_m[i] &
                          ~float_nxt;
      // open drain never drives high, it releases instead
      assign pad_out[i] = drv_val[i] & ~od_m[i];
      assign pad_oe[i]  = drv_en[i] & ~(od_m[i] & drv_val[i]);
      assign pull_on[i] = d.pull[i] & ~nopull_m[i] & impl_m[i] &
                          ~(pad_oe[i] & ~pad_out[i]);
      // floating inputs are clamped low to stop leakage unless an irq needs them
      assign pin_level[i] = pin_sync[i] & ~(float_now & ~irq_keep[i]);
      // output-mode port pins and rmw reads see the latch, others the pin
      assign data_rd[i] = (RMW_READ || (q.dir[i] && !PERIPH_OE[i])) ?
                          q.latch[i] : pin_level[i];
    end
  endgenerate

  always_comb begin
    rd_mux = '0;
    case (PADDR)
      `GPP_ADDR_LATCH: rd_mux[7:0] = data_rd & `GPP_IMPL_MASK;
      `GPP_ADDR_DIR:   rd_mux[7:0] = q.dir;
      `GPP_ADDR_PULL:  rd_mux[7:0] = q.pull;
      `GPP_ADDR_STBY:  rd_mux[`GPP_FLOAT_BIT] = q.flt_sel;
      default:         rd_mux = '0;
    endcase
  end

  always_comb begin
    d = q;
    if (setup_rd) begin
      d.rdata = rd_mux;
    end
    if (access_wr) begin
      case (PADDR)
        `GPP_ADDR_LATCH: d.latch = PWDATA[7:0] & `GPP_IMPL_MASK;
        `GPP_ADDR_DIR:   d.dir   = PWDATA[7:0] & `GPP_IMPL_MASK;
        `GPP_ADDR_PULL:  d.pull  = PWDATA[7:0] & `GPP_IMPL_MASK;
        `GPP_ADDR_STBY:  d.flt_sel = PWDATA[`GPP_FLOAT_BIT];
        default:         d.latch = q.latch;
      endcase
    end
    d.pin_out = pad_out;
    d.pin_oe  = pad_oe;
    d.pull_on = pull_on;
    // interrupt lines follow the pin whatever function it serves
    d.irq_lvl = pin_level & (`GPP_IRQ_MASK | `GPP_ROUTE_MASK);
    d.per_in  = pin_level;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      q         <= '0;
      q.latch   <= `GPP_LATCH_RST;
      q.dir     <= `GPP_DIR_RST;
      q.pull    <= `GPP_PULL_RST;
      q.flt_sel <= `GPP_FLOAT_RST;
    end else if (CLK_EN) begin
      q <= d;
    end
  end

  // zero wait states; a frozen clock enable stretches nothing, so the master
  // must keep CLK_EN high across a transfer
  assign PREADY    = 1'b1;
  assign PSLVERR   = PSEL && PENABLE && !addr_hit;
  assign PRDATA    = q.rdata;
  assign PIN_OUT   = q.pin_out;
  assign PIN_OE    = q.pin_oe;
  assign PULLUP_ON = q.pull_on;
  assign PERIPH_IN = q.per_in;
  assign IRQ_LEVEL = q.irq_lvl;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);

  sequence apb_wr_s(logic [11:0] a);
    CLK_EN && PSEL && PENABLE && PWRITE && (PADDR == a);
  endsequence

  sequence apb_rd_s(logic [11:0] a);
    CLK_EN && PSEL && !PENABLE && !PWRITE && (PADDR == a);
  endsequence

  latch_write_a: assert property (
    apb_wr_s(`GPP_ADDR_LATCH) |=> q.latch == ($past(PWDATA[7:0]) & `GPP_IMPL_MASK))
    else $error("latch write lost");

  dir_reset_a: assert property (disable iff (1'b0)
    $fell(RESET) |-> (q.dir == 8'h00) && (PIN_OE == 8'h00))
    else $error("direction not cleared by reset");

  out_drive_a: assert property (
    apb_wr_s(`GPP_ADDR_DIR) ##1 (CLK_EN && !STOP_WATCH_MODE && PERIPH_OE == 8'h00)
    |=> (PIN_OE & ~`GPP_OD_MASK) == (q.dir & ~`GPP_OD_MASK))
    else $error("output pin not driven");

  latch_read_a: assert property (
    (apb_rd_s(`GPP_ADDR_LATCH) ##0 RMW_READ) |=> PRDATA[7:0] == $past(q.latch))
    else $error("rmw read not from latch");

  pin_read_a: assert property (
    (apb_rd_s(`GPP_ADDR_LATCH) ##0 (!RMW_READ && q.dir == 8'h00 && !float_now))
    |=> PRDATA[7:0] == ($past(pin_sync) & `GPP_IMPL_MASK))
    else $error("input read not from pin");

  out_read_a: assert property (
    (apb_rd_s(`GPP_ADDR_LATCH) ##0 (!RMW_READ && PERIPH_OE == 8'h00 && q.dir == impl_m))
    |=> PRDATA[7:0] == $past(q.latch))
    else $error("output read not from latch");

  input_hold_a: assert property (
    (apb_wr_s(`GPP_ADDR_LATCH) ##0 (q.dir == 8'h00 && PERIPH_OE == 8'h00))
    |=> PIN_OE == 8'h00)
    else $error("input pin driven after latch write");

  out_value_a: assert property (
    (apb_wr_s(`GPP_ADDR_LATCH) ##0 (PERIPH_OE == 8'h00 && !float_nxt))
    |=> (PIN_OUT & PIN_OE & ~od_m) == ($past(PWDATA[7:0]) & q.dir & ~od_m))
    else $error("latch write not on output pin");

  dir_write_a: assert property (
    apb_wr_s(`GPP_ADDR_DIR) |=> q.dir == ($past(PWDATA[7:0]) & impl_m))
    else $error("direction write lost");

  pull_write_a: assert property (
    apb_wr_s(`GPP_ADDR_PULL) |=> q.pull == ($past(PWDATA[7:0]) & impl_m))
    else $error("pull-up write lost");

  periph_oe_a: assert property (
    (CLK_EN && !float_nxt)
    |=> (PIN_OE & ~od_m & $past(PERIPH_OE)) == ($past(PERIPH_OE) & impl_m & ~od_m))
    else $error("peripheral output not driven");

  periph_val_a: assert property (
    (CLK_EN && !float_nxt)
    |=> (PIN_OUT & $past(PERIPH_OE & impl_m))
        == ($past(PERIPH_OUT & PERIPH_OE) & impl_m & ~od_m))
    else $error("peripheral value not on pin");

  periph_in_a: assert property (
    (CLK_EN && !float_now) |=> PERIPH_IN == $past(pin_sync))
    else $error("peripheral input not following pin");

  float_keep_a: assert property (
    (CLK_EN && float_now)
    |=> (PERIPH_IN & $past(irq_keep)) == ($past(pin_sync) & $past(irq_keep)))
    else $error("interrupt pin blocked during float");

  float_off_a: assert property (
    (CLK_EN && STOP_WATCH_MODE && !float_nxt && PERIPH_OE == 8'h00)
    |=> (PIN_OE & ~od_m) == ($past(d.dir) & ~od_m))
    else $error("pin state changed in standby without float");

  pull_on_a: assert property (
    (CLK_EN && PERIPH_OE == 8'h00 && d.dir == 8'h00)
    |=> PULLUP_ON == $past(d.pull & ~nopull_m))
    else $error("pull-up not following its bit");

  bad_read_a: assert property (
    (CLK_EN && setup_rd && !addr_hit) |=> PRDATA == 32'h0)
    else $error("unmapped read not zero");

  // a low enable must freeze every register, synchroniser included
  freeze_a: assert property (
    !CLK_EN |=> (q == $past(q)) && (pin_sync == $past(pin_sync)))
    else $error("state moved with clock enable low");

  float_hiz_a: assert property (
    (CLK_EN && float_nxt) |=> PIN_OE == 8'h00)
    else $error("pin driven during float");

  float_block_a: assert property (
    (CLK_EN && float_now && irq_keep == 8'h00) |=> PERIPH_IN == 8'h00)
    else $error("floating input not blocked");

  pull_low_a: assert property (
    (PULLUP_ON & PIN_OE & ~PIN_OUT) == 8'h00)
    else $error("pull-up on a low driven pin");

  pull_none_a: assert property (
    (PULLUP_ON & (`GPP_NOPULL_MASK | ~`GPP_IMPL_MASK)) == 8'h00)
    else $error("pull-up on a pin without one");

  od_release_a: assert property (
    (PIN_OUT & `GPP_OD_MASK) == 8'h00)
    else $error("open-drain pin driven high");

  unimpl_a: assert property (
    ((q.latch | q.dir | PIN_OE) & ~`GPP_IMPL_MASK) == 8'h00)
    else $error("unimplemented bit set");

  irq_feed_a: assert property (
    (CLK_EN && !float_now)
    |=> IRQ_LEVEL == ($past(pin_sync) & (`GPP_IRQ_MASK | `GPP_ROUTE_MASK)))
    else $error("interrupt level not following pin");
endmodule // gpp_port

// ### tb/gpp_pad_model.sv
// gpp_pad_model.sv: board side of the pads, outside drivers and pull-ups
// assumes: the bench keeps its drivers off pins the port drives
module gpp_pad_model (
  // clock
  input  wire logic               clk,
  // port side
  input  wire gpp_pkg::gpp_byte_t oe,
  input  wire gpp_pkg::gpp_byte_t out,
  input  wire gpp_pkg::gpp_byte_t pull,
  // outside drivers
  input  wire gpp_pkg::gpp_byte_t ext_en,
  input  wire gpp_pkg::gpp_byte_t ext_val,
  output      gpp_pkg::gpp_byte_t lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  import gpp_pkg::*;
  gpp_byte_t last_r = 8'h00;
  // an undriven pad toggles each cycle, so no reader leans on a settled guess
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe[i]) lvl[i] = out[i];
      else if (ext_en[i]) lvl[i] = ext_val[i];
      else if (pull[i]) lvl[i] = 1'b1;
      else lvl[i] = ~last_r[i];
    end
  end
  always_ff @(posedge clk) last_r <= lvl;
endmodule // gpp_pad_model

// ### tb/gpio_port_one_pin_control_tb.sv
// gpio_port_one_pin_control_tb.sv: self-checking bench of gpp_port over apb
// assumes: package, gpp_port and gpp_pad_model compiled first
`include "gpp_defines.svh"
module gpio_port_one_pin_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gpp_pkg::*;
  typedef struct packed {
    gpp_byte_t dir, lat, pul, ext, oe, pu, rd;
  } gpp_row_t;
  // dir, latch, pull, outside level; pad enable, pull-up on, plain read
  gpp_row_t rows [5] = '{
    '{8'h39, 8'h39, 8'hff, 8'h00, 8'h38, 8'h38, 8'h39},
    '{8'h39, 8'h00, 8'h39, 8'hff, 8'h39, 8'h00, 8'h00},
    '{8'h00, 8'hff, 8'h39, 8'h00, 8'h00, 8'h38, 8'h00},
    '{8'h18, 8'h08, 8'h00, 8'h21, 8'h18, 8'h00, 8'h29},
    '{8'hc6, 8'hc6, 8'hc6, 8'hff, 8'h00, 8'h00, 8'h39}};
  gpp_row_t  r;
  logic      REF_CLK, RESET, PSEL, PENABLE, PWRITE, RMW_READ, PREADY, PSLVERR, err_w;
  logic      STOP_WATCH_MODE, IRQ_ROUTE_EN, CLK_EN;
  gpp_addr_t PADDR;
  gpp_word_t PWDATA, PRDATA, rd_w;
  gpp_byte_t PIN_IN, PIN_OUT, PIN_OE, PULLUP_ON, PERIPH_OE, PERIPH_OUT, PERIPH_IN;
  gpp_byte_t EXT_IRQ_EN, IRQ_LEVEL, ext_en, ext_val;
  int        error_cnt = 0;
  int        checks_done = 0;

  gpp_port uut (.REF_CLK, .RESET, .CLK_EN, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RMW_READ, .PIN_IN, .PIN_OUT, .PIN_OE,
    .PULLUP_ON, .PERIPH_OE, .PERIPH_OUT, .PERIPH_IN, .STOP_WATCH_MODE, .EXT_IRQ_EN,
    .IRQ_ROUTE_EN, .IRQ_LEVEL);
  gpp_pad_model pad (.clk(REF_CLK), .oe(PIN_OE), .out(PIN_OUT), .pull(PULLUP_ON),
    .ext_en, .ext_val, .lvl(PIN_IN));

  task automatic chk(input gpp_word_t got, input gpp_word_t exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one transfer; request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic rmw, input gpp_addr_t a, input gpp_byte_t d);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    RMW_READ <= rmw;
    PADDR <= a;
    PWDATA <= 32'(d);
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) @(posedge REF_CLK);
    rd_w = PRDATA;
    err_w = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    RMW_READ <= 1'b0;
  endtask
  task automatic settle();
    repeat (4) @(posedge REF_CLK);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d, errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    REF_CLK = 1'b0;
    forever #50 REF_CLK = ~REF_CLK;
  end
  // whole run is some 200 cycles
  initial begin
    #300us;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {RESET, PSEL, PENABLE, PWRITE, RMW_READ, PADDR, PWDATA} = '0;
    {STOP_WATCH_MODE, IRQ_ROUTE_EN, PERIPH_OE, PERIPH_OUT, EXT_IRQ_EN} = '0;
    {ext_en, ext_val} = '0;
    CLK_EN = 1'b1;
    RESET = 1'b1;
    repeat (12) @(posedge REF_CLK);
    RESET <= 1'b0;
    apb(0, 0, `GPP_ADDR_DIR, 8'h00);
    chk(rd_w, '0);
    chk(32'(PIN_OE), '0);
    foreach (rows[i]) begin
      r = rows[i];
      ext_en <= ~r.dir;
      ext_val <= r.ext;
      apb(1, 0, `GPP_ADDR_DIR, r.dir);
      apb(1, 0, `GPP_ADDR_LATCH, r.lat);
      apb(1, 0, `GPP_ADDR_PULL, r.pul);
      settle();
      chk(32'(PIN_OE), 32'(r.oe));
      chk(32'(PIN_OUT & PIN_OE), 32'(r.lat & r.oe));
      chk(32'(PULLUP_ON & 8'h39), 32'(r.pu));
      chk(32'(PERIPH_IN & ~r.dir & 8'h39), 32'(r.rd & ~r.dir & 8'h39));
      chk(32'(IRQ_LEVEL & 8'h38), 32'(PIN_IN & 8'h38));
      apb(0, 0, `GPP_ADDR_LATCH, 8'h00);
      chk(rd_w, 32'(r.rd));
      apb(0, 1, `GPP_ADDR_LATCH, 8'h00);
      chk(rd_w, 32'(r.lat & 8'h39));
      apb(0, 0, `GPP_ADDR_DIR, 8'h00);
      chk(rd_w, 32'(r.dir & 8'h39));
      apb(0, 0, `GPP_ADDR_PULL, 8'h00);
      chk(rd_w, 32'(r.pul & 8'h39));
    end
    // peripheral drives pin 4, outside holds the rest low
    apb(1, 0, `GPP_ADDR_DIR, 8'h00);
    ext_en <= 8'hef;
    ext_val <= 8'h00;
    PERIPH_OE <= 8'h10;
    PERIPH_OUT <= 8'h10;
    settle();
    chk(32'(PIN_OE & PIN_OUT), 32'h10);
    apb(0, 0, `GPP_ADDR_LATCH, 8'h00);
    chk(rd_w, 32'h10);
    PERIPH_OE <= 8'h00;
    // standby float with pin 5 interrupt enabled, then pin 0 through routing
    apb(1, 0, `GPP_ADDR_LATCH, 8'h38);
    apb(1, 0, `GPP_ADDR_DIR, 8'h39);
    apb(1, 0, `GPP_ADDR_STBY, 8'h01);
    ext_en <= 8'hff;
    ext_val <= 8'hff;
    STOP_WATCH_MODE <= 1'b1;
    settle();
    chk(32'(PIN_OE), '0);
    chk(32'(PERIPH_IN), '0);
    EXT_IRQ_EN <= 8'h20;
    settle();
    chk(32'(PERIPH_IN & 8'h39), 32'h20);
    IRQ_ROUTE_EN <= 1'b1;
    settle();
    chk(32'(PERIPH_IN & 8'h39), 32'h21);
    ext_en <= 8'h00;
    apb(1, 0, `GPP_ADDR_STBY, 8'h00);
    settle();
    chk(32'(PIN_OE), 32'h39);
    chk(32'(PIN_OUT & PIN_OE), 32'h38);
    {STOP_WATCH_MODE, IRQ_ROUTE_EN, EXT_IRQ_EN} <= '0;
    apb(0, 0, 12'h010, 8'h00);
    chk(rd_w, '0);
    chk(32'(err_w), 32'h1);
    // reset in mid-run
    @(posedge REF_CLK);
    RESET <= 1'b1;
    @(posedge REF_CLK);
    RESET <= 1'b0;
    apb(0, 0, `GPP_ADDR_DIR, 8'h00);
    chk(rd_w, '0);
    chk(32'(PIN_OE), '0);
    // a low clock enable freezes the pin path, which then catches up
    ext_en <= 8'hff;
    ext_val <= 8'h00;
    settle();
    CLK_EN <= 1'b0;
    ext_val <= 8'h38;
    settle();
    chk(32'(PERIPH_IN), '0);
    CLK_EN <= 1'b1;
    settle();
    chk(32'(PERIPH_IN & 8'h39), 32'h38);
    wrap_up();
  end
endmodule // gpio_port_one_pin_control_tb
